// File: src/sncfg_pkg.sv
// Notes on behaviour
// RULE1: gating bit set: laser only when illuminating
// RULE2: trigger bit starts tests, 16-bit crc result
// RULE3: loaded patch memory fails test; reset first
// RULE4: laser fault during test gives failure
// RULE5: test ends restoring ram and patch defaults
// RULE6: controller reloads patch image after test
// RULE7: test lasts 200 ms at 24 MHz; code counts 200 ms at CLOCK_HZ of 10 MHz
// RULE8: no serial traffic while test runs
// RULE9: bit 7 read-only busy flag guards bounds
// RULE10: controller waits two frames after period write
// RULE11: pull-up disable bit turns pull-ups off
// RULE12: auto-exposure disable holds shutter at limit
// RULE13: frame rate lock uses period limit
// RULE14: result bytes readable in either order
// RULE15: busy set on period write, cleared after two frames
package sncfg_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_SENSOR_CONFIGURATION   = 7'h0a;
    localparam logic [6:0] ADDR_EXTENDED_CONFIGURATION = 7'h0b;
    localparam logic [6:0] ADDR_RESULT_LOW             = 7'h0c;
    localparam logic [6:0] ADDR_RESULT_HIGH            = 7'h0d;
    localparam logic [6:0] ADDR_PERIOD_LIMIT_UPPER     = 7'h1a;
    localparam logic [7:0] RESET_SENSOR_CONFIGURATION  = 8'h5d;
    localparam logic [7:0] RESET_EXTENDED_CONFIGURATION = 8'h08;
    // fixed bits: cfg bit7 zero, bits4..2 one; ext bit3 one
    localparam logic [7:0] CFG_FIXED_ONES   = 8'h1c;
    localparam logic [7:0] CFG_WRITE_MASK   = 8'h63;
    localparam logic [7:0] EXT_FIXED_ONES   = 8'h08;
    localparam logic [7:0] EXT_WRITE_MASK   = 8'h07;
    localparam int BIT_GATING        = 6;
    localparam int BIT_SELF_TEST     = 5;
    localparam int BIT_BUSY          = 7;
    localparam int BIT_PULLUP_DIS    = 2;
    localparam int BIT_AUTO_EXP_DIS  = 1;
    localparam int BIT_RATE_LOCK     = 0;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int TEST_TIME_MS      = 200;
    localparam int CLOCK_HZ          = 10_000_000;
    localparam int TEST_CYCLES       = TEST_TIME_MS * (CLOCK_HZ / 1000);
    localparam int BUSY_FRAMES       = 2;
    // test outcome words
    localparam logic [15:0] CRC_PASS = 16'ha9d5;
    localparam logic [15:0] CRC_FAIL = 16'h0000;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       write;
        logic [6:0] addr;
        logic [7:0] data;
    } sncfg_access_type;
    typedef struct packed {
        logic laser_gated;
        logic pullup_disable;
        logic auto_exposure_disable;
        logic frame_rate_lock;
    } sncfg_control_type;
    typedef enum logic [1:0] {ST_IDLE, ST_TEST, ST_RESTORE} sncfg_state_type;
endpackage : sncfg_pkg

// File: src/sncfg_regs.sv
`timescale 1ns/1ps
`default_nettype none
module sncfg_regs
    import sncfg_pkg::*;
#(
    parameter int TEST_LEN = TEST_CYCLES
)(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    // access strobe from the serial port decoder
    input  wire logic              acc_valid,
    input  wire sncfg_access_type  acc,
    output logic [7:0]             rd_data,
    // sensor state, from the sensor core
    input  wire logic              frame_done,
    input  wire logic              laser_fault,
    input  wire logic              patch_loaded,
    input  wire logic              illum_needed,
    // outputs
    output sncfg_control_type      ctrl,
    output logic                   laser_on,
    output logic                   test_running,
    output logic                   restore_defaults
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0]      cfg;
    logic [7:0]      ext;
    logic            busy;
    logic [1:0]      frames_seen;
    logic [15:0]     result;
    logic [31:0]     test_count;
    logic            test_bad;
    sncfg_state_type state;
    logic            wr_cfg;
    logic            wr_ext;
    logic            wr_period;
    logic            next_laser_on;

    assign wr_cfg    = acc_valid && acc.write && acc.addr == ADDR_SENSOR_CONFIGURATION;
    assign wr_ext    = acc_valid && acc.write && acc.addr == ADDR_EXTENDED_CONFIGURATION;
    assign wr_period = acc_valid && acc.write && acc.addr == ADDR_PERIOD_LIMIT_UPPER;

    // configuration register, trigger bit self-clears when test starts
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            cfg <= RESET_SENSOR_CONFIGURATION;
        else if (state == ST_RESTORE)
            cfg <= RESET_SENSOR_CONFIGURATION; // [RULE5]
        else if (wr_cfg && state == ST_IDLE)
            cfg <= (acc.data & CFG_WRITE_MASK) | CFG_FIXED_ONES;
        else if (state == ST_TEST)
            cfg[BIT_SELF_TEST] <= 1'b0;
    end

    // extended configuration, busy position not writable
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            ext <= RESET_EXTENDED_CONFIGURATION;
        else if (state == ST_RESTORE)
            ext <= RESET_EXTENDED_CONFIGURATION; // [RULE5]
        else if (wr_ext && state == ST_IDLE)
            ext <= (acc.data & EXT_WRITE_MASK) | EXT_FIXED_ONES; // [RULE9]
    end

    // busy flag: set on period write, cleared after two frames
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busy        <= 1'b0;
            frames_seen <= 2'd0;
        end
        else if (wr_period)
        begin
            busy        <= 1'b1; // [RULE15] [RULE9]
            frames_seen <= 2'd0;
        end
        else if (busy && frame_done)
        begin
            if (frames_seen == 2'(BUSY_FRAMES - 1))
                busy <= 1'b0; // [RULE15]
            frames_seen <= frames_seen + 2'd1;
        end
    end

    // self-test sequencer
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state      <= ST_IDLE;
            test_count <= 32'h0000_0000;
            test_bad   <= 1'b0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (wr_cfg && acc.data[BIT_SELF_TEST])
                    begin
                        state      <= ST_TEST; // [RULE2]
                        test_count <= 32'h0000_0000;
                        test_bad   <= patch_loaded; // [RULE3]
                    end
                ST_TEST:
                begin
                    if (laser_fault)
                        test_bad <= 1'b1; // [RULE4]
                    if (test_count == 32'(TEST_LEN - 1))
                        state <= ST_RESTORE; // [RULE7]
                    else
                        test_count <= test_count + 32'h0000_0001;
                end
                ST_RESTORE:
                    state <= ST_IDLE;
            endcase
        end
    end

    // result word, written when test finishes
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            result <= 16'h0000;
        else if (state == ST_TEST && test_count == 32'(TEST_LEN - 1))
            result <= (test_bad || laser_fault) ? CRC_FAIL : CRC_PASS; // [RULE2] [RULE4]
    end

    // read mux, registered; each result byte independent
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            rd_data <= 8'h00;
        else if (acc_valid && !acc.write)
        begin
            unique case (acc.addr)
                ADDR_SENSOR_CONFIGURATION:   rd_data <= cfg;
                ADDR_EXTENDED_CONFIGURATION: rd_data <= {busy, ext[6:0]}; // [RULE9]
                ADDR_RESULT_LOW:             rd_data <= result[7:0]; // [RULE14]
                ADDR_RESULT_HIGH:            rd_data <= result[15:8]; // [RULE14]
                default:                     rd_data <= 8'h00;
            endcase
        end
    end

    // control outputs
    assign next_laser_on = !cfg[BIT_GATING] || illum_needed; // [RULE1]
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl             <= '0;
            laser_on         <= 1'b0;
            test_running     <= 1'b0;
            restore_defaults <= 1'b0;
        end
        else
        begin
            ctrl.laser_gated           <= cfg[BIT_GATING];
            ctrl.pullup_disable        <= ext[BIT_PULLUP_DIS]; // [RULE11]
            ctrl.auto_exposure_disable <= ext[BIT_AUTO_EXP_DIS]; // [RULE12]
            ctrl.frame_rate_lock       <= ext[BIT_RATE_LOCK]; // [RULE13]
            laser_on                   <= next_laser_on; // [RULE1]
            test_running               <= (state == ST_TEST); // [RULE8]
            restore_defaults           <= (state == ST_RESTORE); // [RULE5]
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_laser_mode;
        @(posedge clk_sys) disable iff (!reset_n)
        !cfg[BIT_GATING] |=> laser_on;
    endproperty
    a_laser_mode: assert property (p_laser_mode) else $error("laser off while ungated"); // [RULE1]

    property p_test_start;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == ST_IDLE && wr_cfg && acc.data[BIT_SELF_TEST]) |=> ##1 test_running;
    endproperty
    a_test_start: assert property (p_test_start) else $error("test did not start"); // [RULE2]

    property p_patch_fail;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == ST_IDLE && wr_cfg && acc.data[BIT_SELF_TEST] && patch_loaded) |=> test_bad;
    endproperty
    a_patch_fail: assert property (p_patch_fail) else $error("patch load not failing"); // [RULE3]

    property p_fault_fail;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == ST_TEST && laser_fault) |=> test_bad || state == ST_RESTORE;
    endproperty
    a_fault_fail: assert property (p_fault_fail) else $error("laser fault ignored"); // [RULE4]

    property p_restore;
        @(posedge clk_sys) disable iff (!reset_n)
        state == ST_RESTORE |=> (cfg == RESET_SENSOR_CONFIGURATION
            && ext == RESET_EXTENDED_CONFIGURATION && restore_defaults);
    endproperty
    a_restore: assert property (p_restore) else $error("defaults not restored"); // [RULE5]

    property p_test_len;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == ST_TEST && test_count < 32'(TEST_LEN - 1)) |=> state == ST_TEST;
    endproperty
    a_test_len: assert property (p_test_len) else $error("test ended early"); // [RULE7]

    property p_busy_set;
        @(posedge clk_sys) disable iff (!reset_n)
        wr_period |=> busy;
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy not set"); // [RULE15]

    property p_busy_hold;
        @(posedge clk_sys) disable iff (!reset_n)
        (busy && !frame_done && !wr_period) |=> busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early"); // [RULE9]

    property p_ctrl;
        @(posedge clk_sys) disable iff (!reset_n)
        ##1 (ctrl.pullup_disable == $past(ext[BIT_PULLUP_DIS])
             && ctrl.frame_rate_lock == $past(ext[BIT_RATE_LOCK])
             && ctrl.auto_exposure_disable == $past(ext[BIT_AUTO_EXP_DIS]));
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control mismatch"); // [RULE11] [RULE12] [RULE13]

    // ------------------------------------------------------------
    // laser, sequencer end and result checks
    // ------------------------------------------------------------
    property p_laser_gated;
        @(posedge clk_sys) disable iff (!reset_n)
        (cfg[BIT_GATING] && !illum_needed) |=> !laser_on;
    endproperty
    a_laser_gated: assert property (p_laser_gated) else $error("laser on while dark"); // [RULE1]

    property p_test_end;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == ST_TEST && test_count == 32'(TEST_LEN - 1)) |=> state == ST_RESTORE;
    endproperty
    a_test_end: assert property (p_test_end) else $error("test overran"); // [RULE7]

    property p_result_pass;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == ST_TEST && test_count == 32'(TEST_LEN - 1) && !test_bad && !laser_fault)
            |=> result == CRC_PASS;
    endproperty
    a_result_pass: assert property (p_result_pass) else $error("pass word wrong"); // [RULE2]

    property p_result_fail;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == ST_TEST && test_count == 32'(TEST_LEN - 1) && (test_bad || laser_fault))
            |=> result == CRC_FAIL;
    endproperty
    a_result_fail: assert property (p_result_fail) else $error("fail word wrong"); // [RULE3] [RULE4]

    property p_test_refuse;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == ST_TEST && wr_cfg) |=> cfg[BIT_GATING] == $past(cfg[BIT_GATING]);
    endproperty
    a_test_refuse: assert property (p_test_refuse) else $error("write taken in test"); // [RULE8]

    property p_pulse;
        @(posedge clk_sys) disable iff (!reset_n)
        restore_defaults |=> !restore_defaults;
    endproperty
    a_pulse: assert property (p_pulse) else $error("restore pulse too long"); // [RULE5]

    // ------------------------------------------------------------
    // busy flag, fixed bit and read path checks
    // ------------------------------------------------------------
    property p_busy_clear;
        @(posedge clk_sys) disable iff (!reset_n)
        (busy && frame_done && !wr_period && frames_seen == 2'(BUSY_FRAMES - 1)) |=> !busy;
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("busy stuck"); // [RULE15]

    property p_busy_idle;
        @(posedge clk_sys) disable iff (!reset_n)
        (!busy && !wr_period) |=> !busy;
    endproperty
    a_busy_idle: assert property (p_busy_idle) else $error("busy set unasked"); // [RULE15]

    property p_fixed_bits;
        @(posedge clk_sys) disable iff (!reset_n)
        (cfg & ~CFG_WRITE_MASK) == CFG_FIXED_ONES && (ext & ~EXT_WRITE_MASK) == EXT_FIXED_ONES;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bit moved"); // [RULE9]

    property p_rd_busy;
        @(posedge clk_sys) disable iff (!reset_n)
        (acc_valid && !acc.write && acc.addr == ADDR_EXTENDED_CONFIGURATION)
            |=> rd_data[BIT_BUSY] == $past(busy);
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("busy read wrong"); // [RULE9]

    property p_rd_high;
        @(posedge clk_sys) disable iff (!reset_n)
        (acc_valid && !acc.write && acc.addr == ADDR_RESULT_HIGH)
            |=> rd_data == $past(result[15:8]);
    endproperty
    a_rd_high: assert property (p_rd_high) else $error("high result read wrong"); // [RULE14]

    property p_rd_low;
        @(posedge clk_sys) disable iff (!reset_n)
        (acc_valid && !acc.write && acc.addr == ADDR_RESULT_LOW)
            |=> rd_data == $past(result[7:0]);
    endproperty
    a_rd_low: assert property (p_rd_low) else $error("low result read wrong"); // [RULE14]
endmodule : sncfg_regs
`default_nettype wire

// File: verif/sncfg_host.sv
`timescale 1ns/1ps
`default_nettype none
module sncfg_host
    import sncfg_pkg::*;
(
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    // request from the bench
    input  wire logic             go,
    input  wire sncfg_access_type req,
    input  wire logic             test_running,
    // access strobe toward the registers
    output logic                  acc_valid,
    output sncfg_access_type      acc
);
    // one-cycle strobe; held off while the self test runs
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            acc_valid <= 1'b0;
            acc       <= '0;
        end
        else if (go && !test_running)
        begin
            acc_valid <= 1'b1;
            acc       <= req;
        end
        else
        begin
            acc_valid <= 1'b0;
            acc       <= ~acc; // released: never the last value
        end
    end
endmodule : sncfg_host
`default_nettype wire

// File: verif/sensor_config_registers_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, want) \
    begin \
        samples_checked++; \
        if ((got) !== (want)) \
        begin \
            n_mismatch++; \
            $display("BAD %0t got %h want %h", $time, got, want); \
        end \
    end
module sensor_config_registers_test
    import sncfg_pkg::*;
;
    localparam int TL = 20;
    logic clk_sys, reset_n, go, frame_done, laser_fault, patch_loaded, illum_needed;
    logic acc_valid, laser_on, test_running, restore_defaults;
    logic [7:0] rd_data, rd;
    sncfg_access_type req, acc;
    sncfg_control_type ctrl;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    // --------------------------------------------------------
    // clock, partner, device
    // --------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    sncfg_host host_u (.clk_sys(clk_sys), .reset_n(reset_n), .go(go), .req(req),
        .test_running(test_running), .acc_valid(acc_valid), .acc(acc));
    sncfg_regs #(.TEST_LEN(TL)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
        .acc_valid(acc_valid), .acc(acc), .rd_data(rd_data), .frame_done(frame_done),
        .laser_fault(laser_fault), .patch_loaded(patch_loaded),
        .illum_needed(illum_needed), .ctrl(ctrl), .laser_on(laser_on),
        .test_running(test_running), .restore_defaults(restore_defaults));
    // --------------------------------------------------------
    // tasks
    // --------------------------------------------------------
    task automatic finish_test;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    // one access through the partner, read data kept in rd
    task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        go  <= 1'b1;
        req <= '{write: w, addr: a, data: d};
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rd = rd_data;
    endtask : access
    task automatic reset_dut;
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
    endtask : reset_dut
    task automatic frame;
        @(posedge clk_sys);
        frame_done <= 1'b1;
        @(posedge clk_sys);
        frame_done <= 1'b0;
    endtask : frame
    task automatic t_basic;
        access(1'b0, ADDR_SENSOR_CONFIGURATION, 8'h00);
        `CHK(rd, 8'h5d)
        `CHK(ctrl, 4'b1000)
        `CHK(laser_on, 1'b0)
        access(1'b1, ADDR_SENSOR_CONFIGURATION, 8'h1c);
        `CHK(laser_on, 1'b1)
        access(1'b1, ADDR_SENSOR_CONFIGURATION, 8'h5d);
        `CHK(laser_on, 1'b0)
        @(posedge clk_sys);
        illum_needed <= 1'b1;
        repeat (2) @(negedge clk_sys);
        `CHK(laser_on, 1'b1)
        access(1'b1, ADDR_EXTENDED_CONFIGURATION, 8'hff);
        `CHK(rd, 8'h5d)
        access(1'b0, ADDR_EXTENDED_CONFIGURATION, 8'h00);
        `CHK(rd, 8'h0f)
        `CHK(ctrl, 4'b1111)
        access(1'b1, ADDR_EXTENDED_CONFIGURATION, 8'h05);
        `CHK(ctrl, 4'b1101)
        access(1'b1, ADDR_EXTENDED_CONFIGURATION, 8'h00);
        `CHK(ctrl, 4'b1000)
    endtask : t_basic
    // busy rises on period write, falls on the second frame
    task automatic t_busy;
        access(1'b1, ADDR_PERIOD_LIMIT_UPPER, 8'h12);
        access(1'b0, ADDR_EXTENDED_CONFIGURATION, 8'h00);
        `CHK(rd, 8'h88)
        frame();
        access(1'b0, ADDR_EXTENDED_CONFIGURATION, 8'h00);
        `CHK(rd, 8'h88)
        frame();
        access(1'b0, ADDR_EXTENDED_CONFIGURATION, 8'h00);
        `CHK(rd, 8'h08)
    endtask : t_busy
    task automatic t_selftest(input logic fault, input logic patch, input logic [15:0] res);
        int n;
        int p;
        n = 0;
        p = 0;
        reset_dut();
        laser_fault  <= fault;
        patch_loaded <= patch;
        // only the trigger is written; other settings stay default until after
        access(1'b1, ADDR_SENSOR_CONFIGURATION, 8'h7d);
        for (int i = 0; i < 60; i++)
        begin
            if (test_running === 1'b1)
                n++;
            if (restore_defaults === 1'b1)
                p++;
            @(negedge clk_sys);
        end
        `CHK(n, TL)
        `CHK(p, 1)
        @(posedge clk_sys);
        laser_fault  <= 1'b0;
        patch_loaded <= 1'b0;
        access(1'b0, ADDR_RESULT_HIGH, 8'h00);
        `CHK(rd, res[15:8])
        access(1'b0, ADDR_RESULT_LOW, 8'h00);
        `CHK(rd, res[7:0])
        access(1'b0, ADDR_EXTENDED_CONFIGURATION, 8'h00);
        `CHK(rd, 8'h08)
        access(1'b0, ADDR_SENSOR_CONFIGURATION, 8'h00);
        `CHK(rd, 8'h5d)
    endtask : t_selftest
    // --------------------------------------------------------
    // main sequence and hang guard
    // --------------------------------------------------------
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            finish_test();
        end
    end
    initial
    begin
        reset_n = 1'b0;
        go = 1'b0;
        req = '0;
        frame_done = 1'b0;
        laser_fault = 1'b0;
        patch_loaded = 1'b0;
        illum_needed = 1'b0;
        reset_dut();
        t_basic();
        t_busy();
        t_selftest(1'b0, 1'b0, CRC_PASS);
        t_selftest(1'b1, 1'b0, CRC_FAIL);
        t_selftest(1'b0, 1'b1, CRC_FAIL);
        access(1'b1, ADDR_EXTENDED_CONFIGURATION, 8'h01);
        access(1'b0, ADDR_EXTENDED_CONFIGURATION, 8'h00);
        `CHK(rd, 8'h09)
        finish_test();
    end
endmodule : sensor_config_registers_test
`default_nettype wire
